// ==== rtl/tacpm_pkg.sv ====
// shared constants for the touch adc control word and power manager
package tacpm_pkg;
    // control word field positions
    localparam int unsigned START_POS = 7;
    localparam int unsigned CHAN_HI = 6;
    localparam int unsigned CHAN_LO = 4;
    localparam int unsigned RES_POS = 3;
    localparam int unsigned REFSEL_POS = 2;
    localparam int unsigned PWR_HI_POS = 1;
    localparam int unsigned PWR_LO_POS = 0;
    localparam int unsigned WORD_BITS = 8;
    // values after reset
    localparam logic [1:0] PWR_RESET = 2'h2;
    localparam logic [2:0] CHAN_RESET = 3'h0;
    // frame timing in falling serial clock edges after the start marker
    localparam logic [4:0] EDGE_ADC_UP = 5'h04;
    localparam logic [4:0] EDGE_CTRL_DONE = 5'h0A;
    localparam logic [4:0] EDGE_CONV_DONE_12 = 5'h14;
    localparam logic [4:0] EDGE_CONV_DONE_8 = 5'h10;
    localparam logic [4:0] EDGE_REARM_12 = 5'h0E;
    localparam logic [4:0] EDGE_REARM_8 = 5'h0A;
    // serial sequencer states
    typedef enum logic [3:0] {
        TACPM_IDLE = 4'h1,
        TACPM_LOAD = 4'h2,
        TACPM_ACQ = 4'h4,
        TACPM_CONV = 4'h8
    } tacpm_state_t;
endpackage

// ==== rtl/tacpm_sync_edge.sv ====
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module tacpm_sync_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // async level in
    input wire logic async_i,
    input wire logic reset_level_i,
    // synchronised level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta;
    logic sync;
    logic last;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= reset_level_i;
            sync <= reset_level_i;
            last <= reset_level_i;
        end else begin
            meta <= async_i;
            sync <= meta;
            last <= sync;
        end
    end

    // flops start at the pin's idle level, so no false edge follows reset
    assign level_o = sync;
    assign rise_o = sync & ~last;
    assign fall_o = ~sync & last;
endmodule // tacpm_sync_edge
`default_nettype wire

// ==== rtl/tacpm_core.sv ====
// control word decoder, serial sequencer and power manager of the touch adc
// How it works
// RULE1 - after reset power_ctl_low is 0 and power_ctl_high is 1
// RULE2 - word starts at first high bit on the serial input, as bit 7
// RULE3 - next word may start after 15 clocks (12-bit) or 11 (8-bit)
// RULE4 - channel bits 6..4 and reference select bit 2 steer mux and drivers
// RULE5 - bit 3 picks 12-bit conversion when 0, 8-bit when 1
// RULE6 - power bits 1 and 0 choose one of four power configurations
// RULE7 - with 00 reference off at once, adc off only between conversions
// RULE8 - low power bit 0: finish conversion, then adc off, or on select release
// RULE9 - adc is back at full power at the next conversion start, no delay
// RULE10 - with 00 the y-minus switch is closed while powered down
// RULE11 - high power bit 0: reference stays off during ratiometric conversions
// RULE12 - with 01 reference off at once and adc on permanently
// RULE13 - with 10 reference on permanently, adc off between conversions
// RULE14 - with 11 everything on and touch alert disabled; otherwise enabled
// RULE15 - reference on/off is independent of adc power
// RULE16 - adc powers up on falling edge 4 and down on falling edge 20; the code powers it down on edge 16 in 8-bit mode
// RULE17 - reference select 1 is single-ended, 0 is ratiometric
// RULE18 - start marker disables the touch alert until new power bits load; the code keeps it off until the frame ends
// RULE19 - power bits take effect when the word completes, at conversion start
// RULE20 - bits before the marker are ignored; later bits load 6 down to 0
// RULE21 - host keeps select low through word and conversion
`timescale 1ns/1ps
`default_nettype none
module tacpm_core
    import tacpm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial pins from the host
    input wire logic select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    // touch sensing
    input wire logic touch_sense_i,
    // touch alert open-drain pin, enable low while driving low
    output logic touch_alert_n_o,
    output logic touch_alert_oe_n_o,
    // decoded control fields
    output logic [2:0] channel_select_bits_o,
    output logic resolution_8bit_o,
    output logic reference_mode_select_o,
    output logic power_ctl_high_o,
    output logic power_ctl_low_o,
    // analog power and switch controls, conversion status
    output logic reference_on_o,
    output logic adc_powered_o,
    output logic ymin_switch_on_o,
    output logic sample_hold_o,
    output logic converting_o,
    output logic word_ready_o
);
    // synchronised pins and their edges
    logic sel_n;
    logic sel_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic din;
    logic din_meta;
    logic touch;
    // sequencer
    tacpm_state_t state;
    tacpm_state_t next_state;
    logic [4:0] edge_cnt;
    logic [6:0] shift;
    // loaded control word and power state
    logic [2:0] chan;
    logic res8;
    logic refsel;
    logic [1:0] pwr;
    logic [2:0] pwr_cfg;
    logic alert_en;
    logic adc_active;
    // frame events
    logic marker_seen;
    logic word_loaded;
    logic conv_start;
    logic frame_end;

    tacpm_sync_edge u_sclk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(serial_clock_i),
        .reset_level_i(1'b0),
        .level_o(),
        .rise_o(sclk_rise),
        .fall_o(sclk_fall)
    );

    tacpm_sync_edge u_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(select_n_i),
        .reset_level_i(1'b1),
        .level_o(sel_n),
        .rise_o(sel_rise),
        .fall_o()
    );

    // panel touch level is asynchronous as well
    tacpm_sync_edge u_touch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(touch_sense_i),
        .reset_level_i(1'b0),
        .level_o(touch),
        .rise_o(),
        .fall_o()
    );

    // data pin also needs two flops; sampled on the synchronised clock rise
    logic din_sync;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end else begin
            din_meta <= serial_data_i;
            din_sync <= din_meta;
        end
    end
    assign din = din_sync;

    function automatic logic [4:0] conv_done_edge(input logic is8);
        conv_done_edge = is8 ? EDGE_CONV_DONE_8 : EDGE_CONV_DONE_12;
    endfunction

    function automatic logic [4:0] rearm_edge(input logic is8);
        rearm_edge = is8 ? EDGE_REARM_8 : EDGE_REARM_12;
    endfunction

    // power configuration: {reference on, adc kept on, alert allowed}
    function automatic logic [2:0] power_decode(input logic [1:0] p);
        case (p)
            2'h0: power_decode = 3'h1; // RULE7 RULE10
            2'h1: power_decode = 3'h3; // RULE12
            2'h2: power_decode = 3'h5; // RULE13
            2'h3: power_decode = 3'h6; // RULE14
            default: power_decode = 3'h1;
        endcase
    endfunction

    assign pwr_cfg = power_decode(pwr); // RULE6
    // frame events seen from the sequencer
    assign marker_seen = next_state == TACPM_LOAD && state != TACPM_LOAD;
    assign word_loaded = state == TACPM_LOAD && next_state == TACPM_ACQ;
    assign conv_start = state == TACPM_ACQ && next_state == TACPM_CONV;
    assign frame_end = state != TACPM_IDLE && next_state == TACPM_IDLE;

    // sequencer: idle until first high bit, then count falling edges
    always_comb begin
        next_state = state;
        case (state)
            TACPM_IDLE: begin
                if (sclk_rise && din && !sel_n) begin
                    next_state = TACPM_LOAD; // RULE2 RULE20
                end
            end
            TACPM_LOAD: begin
                if (sclk_fall && edge_cnt == 5'(WORD_BITS - 1)) begin
                    next_state = TACPM_ACQ;
                end
            end
            TACPM_ACQ: begin
                if (sclk_fall && edge_cnt == EDGE_CTRL_DONE - 5'h01) begin
                    next_state = TACPM_CONV; // RULE19
                end
            end
            TACPM_CONV: begin
                if (sclk_fall && edge_cnt == conv_done_edge(res8) - 5'h01) begin
                    next_state = TACPM_IDLE;
                end
            end
            default: next_state = TACPM_IDLE;
        endcase
        // overlapped next word may start once the rearm point is passed
        if (state == TACPM_CONV && sclk_rise && din && !sel_n
            && edge_cnt >= rearm_edge(res8)) begin
            next_state = TACPM_LOAD; // RULE3
        end
        if (sel_n) begin
            next_state = TACPM_IDLE; // RULE21
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= TACPM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // falling-edge counter, zero at the start marker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_cnt <= 5'h00;
        end else if (marker_seen) begin
            // a new marker restarts the count, even in mid-conversion
            edge_cnt <= 5'h00;
        end else if (state != TACPM_IDLE && sclk_fall) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // word bits after the marker shift in msb first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift <= 7'h00;
        end else if (state == TACPM_LOAD && sclk_rise) begin
            shift <= {shift[5:0], din}; // RULE20
        end
    end

    // mux fields update as soon as the word is in, as acquisition starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan <= CHAN_RESET;
            res8 <= 1'b0;
            refsel <= 1'b1;
        end else if (word_loaded) begin
            // all seven bits are in by the eighth falling edge
            chan <= shift[CHAN_HI:CHAN_LO]; // RULE4
            res8 <= shift[RES_POS]; // RULE5
            refsel <= shift[REFSEL_POS]; // RULE17
        end
    end

    // power bits only take effect at conversion start
    logic [1:0] pwr_pending;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_pending <= PWR_RESET;
        end else if (word_loaded) begin
            pwr_pending <= shift[PWR_HI_POS:PWR_LO_POS]; // RULE6
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr <= PWR_RESET; // RULE1
        end else if (conv_start) begin
            // old power state rules until acquisition ends
            pwr <= pwr_pending; // RULE19 RULE6
        end
    end

    // alert enable: cleared by a marker, reloaded from new power bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alert_en <= 1'b1;
        end else if (marker_seen) begin
            alert_en <= 1'b0; // RULE18
        end else if (frame_end) begin
            // covers conversion end and a select release in mid-frame
            alert_en <= pwr_cfg[0]; // RULE14
        end else if (state == TACPM_IDLE && alert_en == 1'b0 && sel_rise) begin
            alert_en <= pwr_cfg[0];
        end
    end

    // adc busy window: edge 4 to conversion end, cut by select release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_active <= 1'b0;
        end else if (sel_rise || sel_n) begin
            adc_active <= 1'b0; // RULE8
        end else if (state != TACPM_IDLE && sclk_fall && edge_cnt == EDGE_ADC_UP - 5'h01) begin
            adc_active <= 1'b1; // RULE16 RULE9
        end else if (state == TACPM_CONV && next_state == TACPM_IDLE) begin
            adc_active <= 1'b0; // RULE16
        end
    end

    // registered field outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_select_bits_o <= CHAN_RESET;
            resolution_8bit_o <= 1'b0;
            reference_mode_select_o <= 1'b1;
        end else begin
            channel_select_bits_o <= chan;
            resolution_8bit_o <= res8;
            reference_mode_select_o <= refsel;
        end
    end

    // registered power bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_ctl_high_o <= PWR_RESET[PWR_HI_POS];
            power_ctl_low_o <= PWR_RESET[PWR_LO_POS];
        end else begin
            power_ctl_high_o <= pwr[PWR_HI_POS];
            power_ctl_low_o <= pwr[PWR_LO_POS];
        end
    end

    // analog power and switch controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reference_on_o <= 1'b1;
            adc_powered_o <= 1'b0;
            ymin_switch_on_o <= 1'b0;
        end else begin
            // reference follows the high bit alone, so ratiometric frames never wake it
            reference_on_o <= pwr_cfg[2]; // RULE7 RULE11 RULE12 RULE13 RULE15
            // busy window wakes the adc in the power-down configurations
            adc_powered_o <= pwr_cfg[1] | adc_active; // RULE7 RULE9 RULE12 RULE13 RULE14
            ymin_switch_on_o <= (pwr == 2'h0) & ~adc_active; // RULE10
        end
    end

    // conversion status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_hold_o <= 1'b0;
            converting_o <= 1'b0;
            word_ready_o <= 1'b0;
        end else begin
            // hold and busy share one level; the track stage has no timing of its own
            sample_hold_o <= (state == TACPM_CONV);
            converting_o <= (state == TACPM_CONV);
            word_ready_o <= conv_start; // RULE19
        end
    end

    // open drain alert: pulled low only while touched and enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // the pin only ever pulls low; the pull-up gives the idle high
            touch_alert_n_o <= 1'b0;
            touch_alert_oe_n_o <= 1'b1;
        end else begin
            touch_alert_n_o <= 1'b0;
            touch_alert_oe_n_o <= ~(alert_en & touch); // RULE14 RULE18
        end
    end
endmodule // tacpm_core
`default_nettype wire

// ==== rtl/unused_placeholder_none.sv ====
// holds no logic of its own
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/tacpm_host_model.sv ====
// host serial port model driving select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module tacpm_host_model (
    // clock
    input wire logic clk_i,
    // serial pins towards the core
    output logic select_n_o,
    output logic serial_clock_o,
    output logic serial_data_o,
    output var int edges_o
);
    initial begin
        select_n_o = 1'b1;
        serial_clock_o = 1'b0;
        serial_data_o = 1'b0;
        edges_o = 0;
    end

    // clock stands low outside frames; 8 clk per serial period
    task automatic send(input logic [63:0] bits, input int n);
        @(posedge clk_i) select_n_o <= 1'b0;
        edges_o <= 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i) serial_data_o <= bits[63 - i];
            repeat (3) @(posedge clk_i);
            serial_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            serial_clock_o <= 1'b0;
            edges_o <= i + 1;
        end
        repeat (4) @(posedge clk_i);
        select_n_o <= 1'b1;
        // deselected data must not look like a held bit
        serial_data_o <= ~serial_data_o;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // tacpm_host_model
`default_nettype wire

// ==== bench/tacpm_core_sva.sv ====
// port assertions of the touch adc control core
`timescale 1ns/1ps
`default_nettype none
module tacpm_core_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched pins
    input wire logic select_n_i,
    input wire logic touch_alert_n_o,
    input wire logic touch_alert_oe_n_o,
    input wire logic power_ctl_high_o,
    input wire logic power_ctl_low_o,
    input wire logic reference_on_o,
    input wire logic adc_powered_o,
    input wire logic ymin_switch_on_o,
    input wire logic converting_o,
    input wire logic word_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence release_s;
        $rose(select_n_i) && !power_ctl_low_o;
    endsequence

    reset_state_a: assert property ($fell(rst_i) |-> power_ctl_high_o && !power_ctl_low_o
        && reference_on_o && !adc_powered_o) else $error("bad state after reset");
    ref_follow_a: assert property (reference_on_o == power_ctl_high_o)
        else $error("reference not following high bit");
    adc_kept_a: assert property (power_ctl_low_o && $past(power_ctl_low_o) |-> adc_powered_o)
        else $error("adc off with low bit set");
    ymin_idle_a: assert property (ymin_switch_on_o |-> !power_ctl_high_o
        && !power_ctl_low_o && !adc_powered_o) else $error("y switch on outside power-down");
    alert_off_a: assert property (power_ctl_high_o && power_ctl_low_o
        && $past(power_ctl_low_o) |-> touch_alert_oe_n_o) else $error("alert active in 11");
    alert_level_a: assert property (!touch_alert_n_o)
        else $error("open drain data not low");
    ready_pulse_a: assert property (word_ready_o |=> !word_ready_o)
        else $error("word ready longer than one cycle");
    conv_power_a: assert property ($rose(converting_o) |-> adc_powered_o)
        else $error("conversion without adc power");
    select_drop_a: assert property (release_s |-> ##[1:8] !adc_powered_o)
        else $error("adc kept on after select release");
endmodule // tacpm_core_sva

bind tacpm_core tacpm_core_sva u_sva (.clk_i, .rst_i, .select_n_i, .touch_alert_n_o,
    .touch_alert_oe_n_o, .power_ctl_high_o, .power_ctl_low_o, .reference_on_o,
    .adc_powered_o, .ymin_switch_on_o, .converting_o, .word_ready_o);
`default_nettype wire

// ==== bench/tacpm_core_tb_top.sv ====
// self-checking bench of the touch adc control core
`timescale 1ns/1ps
`default_nettype none
module tacpm_core_tb_top;
    logic clk_i, rst_i, select_n_i, serial_clock_i, serial_data_i, touch_sense_i;
    logic touch_alert_n_o, touch_alert_oe_n_o, resolution_8bit_o, reference_mode_select_o;
    logic power_ctl_high_o, power_ctl_low_o, reference_on_o, adc_powered_o;
    logic ymin_switch_on_o, sample_hold_o, converting_o, word_ready_o;
    logic [2:0] channel_select_bits_o;
    int edges;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;

    tacpm_core DUT (.clk_i, .rst_i, .select_n_i, .serial_clock_i, .serial_data_i,
        .touch_sense_i, .touch_alert_n_o, .touch_alert_oe_n_o, .channel_select_bits_o,
        .resolution_8bit_o, .reference_mode_select_o, .power_ctl_high_o, .power_ctl_low_o,
        .reference_on_o, .adc_powered_o, .ymin_switch_on_o, .sample_hold_o, .converting_o,
        .word_ready_o);
    tacpm_host_model host (.clk_i, .select_n_o(select_n_i), .serial_clock_o(serial_clock_i),
        .serial_data_o(serial_data_i), .edges_o(edges));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the run is about 1660 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic t_reset();
        chk("power bits", 3'h2, {1'b0, power_ctl_high_o, power_ctl_low_o});
        chk("ref adc", 3'h2, {1'b0, reference_on_o, adc_powered_o});
        touch_sense_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("alert", 3'h0, {2'h0, touch_alert_oe_n_o});
        $display("test reset done");
    endtask

    // leading zeros precede the marker; touch held so a live alert shows
    task automatic t_frame(input logic [1:0] pd);
        logic [7:0] w;
        w = {1'b1, 3'h7 - {pd, 1'b0}, pd[0], ~pd[1], pd};
        fork
            host.send({3'h0, w, 53'h0}, 27);
            begin
                wait (edges == 15);
                repeat (4) @(posedge clk_i);
                chk("busy", 3'h7, {adc_powered_o, converting_o, touch_alert_oe_n_o});
                chk("hold", 3'h1, {2'h0, sample_hold_o});
            end
        join
        chk("channel", w[6:4], channel_select_bits_o);
        chk("res ref", {1'b0, w[3:2]}, {1'b0, resolution_8bit_o, reference_mode_select_o});
        chk("power", {1'b0, pd}, {1'b0, power_ctl_high_o, power_ctl_low_o});
        chk("analog", {pd, pd == 2'h0}, {reference_on_o, adc_powered_o, ymin_switch_on_o});
        chk("alert", {2'h0, pd == 2'h3}, {2'h0, touch_alert_oe_n_o});
        $display("test frame %0d done", pd);
    endtask

    task automatic t_b2b(input logic res);
        logic [63:0] s;
        int gap;
        gap = res ? 11 : 15;
        s = {1'b1, 3'h2, res, 3'h7, 56'h0} | ({1'b1, 3'h6, res, 3'h1, 56'h0} >> gap);
        host.send(s, gap + 24);
        chk("second word", 3'h6, channel_select_bits_o);
        chk("second power", 3'h1, {reference_mode_select_o, power_ctl_high_o, power_ctl_low_o});
        $display("test back to back %0d done", res);
    endtask

    // select released after edge 12, before the conversion ends
    task automatic t_early();
        host.send({8'h80, 56'h0}, 12);
        chk("early release", 3'h0, {adc_powered_o, converting_o, power_ctl_low_o});
        chk("early alert", 3'h0, {2'h0, touch_alert_oe_n_o});
        $display("test early release done");
    endtask

    initial begin
        rst_i = 1'b1;
        touch_sense_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_reset();
        for (int pd = 0; pd < 4; pd++) begin
            t_frame(2'(pd));
        end
        t_b2b(1'b0);
        t_b2b(1'b1);
        t_early();
        results();
    end
endmodule // tacpm_core_tb_top
`default_nettype wire
